//--- shared/iav_regs.svh
`ifndef IAV_REGS_SVH
`define IAV_REGS_SVH

// Vector slot = vector value / 4
`define IAV_NSRC        64
`define IAV_NMASK_SLOTS 10
`define IAV_VEC_BASE    24'hFFFF00
`define IAV_VEC_AREA    24'h000100
`define IAV_MASK_RESET  3'h7
`define IAV_LVL_NMI     3'h7
`define IAV_LVL_MAX_MSK 3'h6
`define IAV_LVL_MIN_MSK 3'h1
`define IAV_STACK_STEP  24'h000004
`define IAV_SR_MASK_LSB 12
`define IAV_VALID_SLOTS 64'h0000_8003_4FD0_3FFF

`define IAV_SLOT_TRAP0  6'h00
`define IAV_SLOT_TRAP2  6'h02
`define IAV_SLOT_NMI    6'h08
`define IAV_SLOT_WDOG   6'h09
`define IAV_SLOT_EXT0   6'h0A
`define IAV_SLOT_SFRWP  6'h14
`define IAV_SLOT_TMR8   6'h16
`define IAV_SLOT_T16OVF 6'h1E
`define IAV_SLOT_SRX    6'h20
`define IAV_SLOT_STX    6'h21
`define IAV_SLOT_I2C    6'h2F

`endif

//--- shared/iav_pkg.sv
`include "iav_regs.svh"

package iav_pkg;

  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_PUSHPC = 8'h02,
    ST_PUSHSR = 8'h04,
    ST_FETCH  = 8'h08,
    ST_FIRST  = 8'h10,
    ST_POPSR  = 8'h20,
    ST_POPPC  = 8'h40
  } seq_t;

  typedef struct packed {
    seq_t        st;
    logic [63:0] pend;
    logic [2:0]  mask;
    logic [7:0]  nest;
    logic [23:0] sp;
    logic [5:0]  idx;
    logic [2:0]  lvl;
    logic        memReq;
    logic        memWe;
    logic [23:0] memAddr;
    logic [31:0] memWdata;
    logic        vecValid;
    logic [15:0] vecOut;
    logic [7:0]  dmaVec;
    logic        handlerValid;
    logic [23:0] handlerAddr;
    logic        retValid;
    logic [23:0] retPc;
    logic [15:0] retSr;
    logic        busy;
  } ctl_t;

endpackage

//--- shared/arb_if.sv
`timescale 1ns/1ps

interface arb_if;
  logic [63:0]  req;
  logic [191:0] lvl;
  logic         found;
  logic [5:0]   winIdx;
  logic [2:0]   winLvl;

  modport ctl (output req, output lvl, input found, input winIdx, input winLvl);
  modport arb (input req, input lvl, output found, output winIdx, output winLvl);
endinterface

//--- hdl/level_arbiter.sv
`timescale 1ns/1ps

module level_arbiter import iav_pkg::*; (
  arb_if.arb a
);

  // Downward scan with >= so the smallest slot wins a tie
  always_comb begin
    a.found  = 1'b0;
    a.winIdx = 6'h00;
    a.winLvl = 3'h0;
    for (int i = 63; i >= 0; i--) begin
      if (a.req[i] && a.lvl[3*i +: 3] >= a.winLvl) begin
        a.found  = 1'b1;
        a.winIdx = 6'(i);
        a.winLvl = a.lvl[3*i +: 3];
      end
    end
  end
endmodule

//--- hdl/interrupt_accept_vector.sv
// Contract
// - On acceptance the winning vector is presented first.
// - Equal-level ties resolved by fixed ordering; chosen pending bit cleared.
// - At equal level, smaller vector value wins over larger one.
// - PC and status word pushed on the system stack.
// - Mask loaded with accepted level plus one, or 7 for level 7.
// - Nesting counter increments on each acceptance.
// - Handler address read from vector base plus vector, then jumped to.
// - Return restores PC and status word, nesting counter decrements.
// - Non-maskable always serviced; maskable at level 0 or 7 never.
// - Accept when request level is at least the mask level.
// - Requests passing the raised mask nest inside a running handler.
// - New requests wait until the handler's first instruction completes.
// - Reset sets mask level to 7.
// - Vector area is the top 256 bytes, four bytes per entry.
// - Reset/trap 0 at vector 0, traps four apart, pin NMI at 20H.
// - Illegal instruction raises the trap 2 vector.
// - External pins 0..3 use vectors 28H..34H, DMA vectors 0AH..0DH.
// - Register write protection uses vector 50H, DMA vector 14H.
// - 8-bit timers at 58H upward, four apart, DMA vector 16H.
// - 16-bit timer overflow at 78H, DMA vector 1EH.
// - Serial receive at 80H with DMA 20H, transmit at 84H.
// - I2C transfer end has its own vector, BCH.
// - Only the highest-level pending request is forwarded.
// - Non-maskable carry level 7; maskable levels 1..6 effective.
`timescale 1ns/1ps
`include "iav_regs.svh"

module interrupt_accept_vector import iav_pkg::*; (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // Sources, one bit per vector slot; levels three bits per slot
  input  wire logic [63:0]  srcReq,
  input  wire logic         illegalInst,
  input  wire logic [63:0]  swClr,
  input  wire logic [191:0] srcLevel,
  // Core execution side
  input  wire logic         instrDone,
  input  wire logic         eiStrobe,
  input  wire logic [2:0]   eiLevel,
  input  wire logic         retiReq,
  input  wire logic         spLoad,
  input  wire logic [23:0]  spValue,
  input  wire logic [23:0]  curPc,
  input  wire logic [15:0]  curSr,
  // Memory port
  output logic              memReq,
  output logic              memWe,
  output logic [23:0]       memAddr,
  output logic [31:0]       memWdata,
  input  wire logic         memAck,
  input  wire logic [31:0]  memRdata,
  // Vectoring results
  output logic              vecValid,
  output logic [15:0]       vecOut,
  output logic [7:0]        dmaVec,
  output logic              handlerValid,
  output logic [23:0]       handlerAddr,
  output logic              retValid,
  output logic [23:0]       retPc,
  output logic [15:0]       retSr,
  // Status
  output logic [2:0]        maskLevel,
  output logic [7:0]        nestDepth,
  output logic [23:0]       stackPtr,
  output logic              busy
);

  ctl_t        q;
  ctl_t        d;
  logic [63:0] reqIn;
  logic [63:0] winOneHot;
  logic        accept;

  arb_if arb ();

  level_arbiter u_arb (
    .a (arb)
  );

  // Illegal opcode shares the trap 2 slot
  always_comb begin
    reqIn = srcReq;
    reqIn[`IAV_SLOT_TRAP2] = srcReq[`IAV_SLOT_TRAP2] | illegalInst;
  end

  // Effective level per slot; disabled settings drop out of arbitration
  for (genvar i = 0; i < 64; i++) begin : g_lvl
    logic ok;
    if (i < `IAV_NMASK_SLOTS) begin : g_nm
      assign ok = 1'b1;
      assign arb.lvl[3*i +: 3] = `IAV_LVL_NMI;
    end else begin : g_m
      // Programmed level only matters for maskable slots
      logic [2:0] prog;
      assign prog = srcLevel[3*i +: 3];
      assign ok = (prog >= `IAV_LVL_MIN_MSK) && (prog <= `IAV_LVL_MAX_MSK);
      assign arb.lvl[3*i +: 3] = ok ? prog : 3'h0;
    end
    assign arb.req[i] = q.pend[i] & ok;
  end

  // Evaluation happens only at an instruction boundary outside the sequence
  assign accept = q.st == ST_IDLE && !retiReq && instrDone
                  && arb.found && arb.winLvl >= q.mask;
  assign winOneHot = accept ? (64'h0000_0000_0000_0001 << arb.winIdx) : 64'h0;

  always_comb begin
    d = q;
    d.vecValid     = 1'b0;
    d.handlerValid = 1'b0;
    d.retValid     = 1'b0;
    // Set wins over either clear
    d.pend = (q.pend & ~swClr & ~winOneHot)
             | (reqIn & `IAV_VALID_SLOTS);
    if (spLoad && q.st == ST_IDLE) begin
      d.sp = spValue;
    end
    unique case (q.st)
      ST_IDLE: begin
        if (eiStrobe) begin
          d.mask = eiLevel;
        end
        if (retiReq) begin
          d.memReq  = 1'b1;
          d.memWe   = 1'b0;
          d.memAddr = q.sp;
          d.busy    = 1'b1;
          d.st      = ST_POPSR;
        end else if (accept) begin
          d.idx      = arb.winIdx;
          d.lvl      = arb.winLvl;
          d.vecValid = 1'b1;
          d.vecOut   = {8'h00, arb.winIdx, 2'b00};
          // Non-maskable slots have no DMA start vector
          d.dmaVec   = (arb.winIdx < 6'(`IAV_NMASK_SLOTS)) ? 8'h00
                       : {2'b00, arb.winIdx};
          d.sp       = q.sp - `IAV_STACK_STEP;
          d.memReq   = 1'b1;
          d.memWe    = 1'b1;
          d.memAddr  = q.sp - `IAV_STACK_STEP;
          d.memWdata = {8'h00, curPc};
          d.busy     = 1'b1;
          d.st       = ST_PUSHPC;
        end
      end
      ST_PUSHPC: begin
        if (memAck) begin
          d.sp       = q.sp - `IAV_STACK_STEP;
          d.memAddr  = q.sp - `IAV_STACK_STEP;
          d.memWdata = {16'h0000, curSr};
          d.st       = ST_PUSHSR;
        end
      end
      ST_PUSHSR: begin
        if (memAck) begin
          d.mask    = (q.lvl == 3'h7) ? 3'h7 : q.lvl + 3'h1;
          d.nest    = q.nest + 8'h01;
          d.memWe   = 1'b0;
          d.memAddr = `IAV_VEC_BASE | {16'h0000, q.vecOut[7:0]};
          d.st      = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (memAck) begin
          d.memReq       = 1'b0;
          d.handlerAddr  = memRdata[23:0];
          d.handlerValid = 1'b1;
          d.st           = ST_FIRST;
        end
      end
      ST_FIRST: begin
        // Hold off the next evaluation for one handler instruction
        if (instrDone) begin
          d.busy = 1'b0;
          d.st   = ST_IDLE;
        end
      end
      ST_POPSR: begin
        if (memAck) begin
          d.retSr   = memRdata[15:0];
          d.mask    = memRdata[`IAV_SR_MASK_LSB +: 3];
          d.sp      = q.sp + `IAV_STACK_STEP;
          d.memAddr = q.sp + `IAV_STACK_STEP;
          d.st      = ST_POPPC;
        end
      end
      ST_POPPC: begin
        if (memAck) begin
          d.memReq   = 1'b0;
          d.retPc    = memRdata[23:0];
          d.retValid = 1'b1;
          d.sp       = q.sp + `IAV_STACK_STEP;
          d.nest     = q.nest - 8'h01;
          d.busy     = 1'b0;
          d.st       = ST_IDLE;
        end
      end
      default: begin
        d.st     = ST_IDLE;
        d.memReq = 1'b0;
        d.busy   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q      <= '0;
      q.st   <= ST_IDLE;
      q.mask <= `IAV_MASK_RESET;
    end else begin
      q <= d;
    end
  end

  assign memReq       = q.memReq;
  assign memWe        = q.memWe;
  assign memAddr      = q.memAddr;
  assign memWdata     = q.memWdata;
  assign vecValid     = q.vecValid;
  assign vecOut       = q.vecOut;
  assign dmaVec       = q.dmaVec;
  assign handlerValid = q.handlerValid;
  assign handlerAddr  = q.handlerAddr;
  assign retValid     = q.retValid;
  assign retPc        = q.retPc;
  assign retSr        = q.retSr;
  assign maskLevel    = q.mask;
  assign nestDepth    = q.nest;
  assign stackPtr     = q.sp;
  assign busy         = q.busy;
endmodule

//--- verif/iav_properties.sv
`timescale 1ns/1ps

module iav_properties (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Memory port
  input wire logic        memReq,
  input wire logic        memWe,
  input wire logic [23:0] memAddr,
  input wire logic        memAck,
  input wire logic [31:0] memRdata,
  // Results and status
  input wire logic        vecValid,
  input wire logic [15:0] vecOut,
  input wire logic [7:0]  dmaVec,
  input wire logic        handlerValid,
  input wire logic [23:0] handlerAddr,
  input wire logic        retValid,
  input wire logic [2:0]  maskLevel,
  input wire logic [7:0]  nestDepth,
  input wire logic        busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_rst; $rose(rst_n) |-> maskLevel == 3'h7 && nestDepth == 8'h00; endproperty
  property p_push; vecValid |-> memReq && memWe && busy; endproperty
  property p_idle; vecValid |-> !$past(busy); endproperty
  property p_dma;
    vecValid |-> dmaVec == ((vecOut >= 16'h0028) ? vecOut[9:2] : 8'h00);
  endproperty
  property p_fetch; handlerValid |-> $past(memAddr) == {16'hFFFF, vecOut[7:0]}; endproperty
  property p_hdata; handlerValid |-> handlerAddr == $past(memRdata[23:0]); endproperty
  property p_nest;
    nestDepth != $past(nestDepth) |->
      (nestDepth - $past(nestDepth) == 8'h01) || ($past(nestDepth) - nestDepth == 8'h01);
  endproperty
  property p_hold; memReq && !memAck |=> memReq && $stable(memAddr); endproperty

  a_rst: assert property (p_rst) else $error("mask or nesting wrong after reset");
  a_push: assert property (p_push) else $error("vector without stack write");
  a_idle: assert property (p_idle) else $error("accept while busy");
  a_dma: assert property (p_dma) else $error("dma vector mismatch");
  a_fetch: assert property (p_fetch) else $error("vector fetch address wrong");
  a_hdata: assert property (p_hdata) else $error("handler address wrong");
  a_nest: assert property (p_nest) else $error("nesting step not one");
  a_hold: assert property (p_hold) else $error("memory request dropped");

  c_nmi: cover property (vecValid && vecOut == 16'h0020);
  c_ret: cover property (retValid);
  c_deep: cover property (nestDepth == 8'h03);
endmodule

//--- verif/cpu_mem_model.sv
`timescale 1ns/1ps

module cpu_mem_model (
  // Clock and pace
  input  wire logic        clk_sys,
  input  wire logic        slow,
  // Memory port
  input  wire logic        memReq,
  input  wire logic        memWe,
  input  wire logic [23:0] memAddr,
  input  wire logic [31:0] memWdata,
  output logic             memAck,
  output logic [31:0]      memRdata
);
  logic [31:0] store [logic [23:0]];
  logic        waited = 1'b0;

  // Data is inverted at release and on every idle edge, so a stale read alternates with the true value
  always @(negedge clk_sys) begin
    if (memAck || !memReq) begin
      memAck = 1'b0;
      memRdata = ~memRdata;
    end else if (slow && !waited) begin
      waited = 1'b1;
    end else begin
      waited = 1'b0;
      memAck = 1'b1;
      if (memWe) store[memAddr] = memWdata;
      if (memAddr[23:8] == 16'hFFFF) memRdata = {16'h0040, 8'h00, memAddr[7:0]};
      else memRdata = store.exists(memAddr) ? store[memAddr] : 32'h0;
    end
  end
endmodule

//--- verif/interrupt_accept_vector_tb.sv
`timescale 1ns/1ps

module interrupt_accept_vector_tb;
  logic         clk_sys, rst_n, illegalInst, instrDone, eiStrobe, retiReq, spLoad, slow;
  logic         memReq, memWe, memAck, vecValid, handlerValid, retValid, busy;
  logic [2:0]   eiLevel, maskLevel;
  logic [7:0]   dmaVec, nestDepth;
  logic [15:0]  curSr, vecOut, retSr;
  logic [23:0]  spValue, curPc, memAddr, handlerAddr, retPc, stackPtr;
  logic [31:0]  memWdata, memRdata;
  logic [63:0]  srcReq, swClr;
  logic [191:0] srcLevel;
  int           fail_count, compares, cycles;

  interrupt_accept_vector u_dut (.*);
  cpu_mem_model u_mem (.*);

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask

  task automatic raise(ref logic [63:0] s, input logic [63:0] m);
    @(negedge clk_sys);
    s = m;
    @(negedge clk_sys);
    s = '0;
  endtask

  task automatic waitHi(ref logic s);
    for (int k = 0; k < 30 && s !== 1'b1; k++) @(negedge clk_sys);
  endtask

  task automatic ei(input logic [2:0] l);
    eiLevel = l;
    pulse(eiStrobe);
  endtask

  task automatic acc(input logic [15:0] v, input logic [7:0] d, input logic [2:0] m,
                     input logic [7:0] n);
    pulse(instrDone);
    waitHi(vecValid);
    chk("vecOut", v, vecOut);
    chk("dmaVec", d, dmaVec);
    waitHi(handlerValid);
    chk("handlerAddr", {8'h40, 8'h00, v[7:0]}, handlerAddr);
    chk("maskLevel", m, maskLevel);
    chk("nestDepth", n, nestDepth);
    chk("stackPtr", 32'(spValue) - 32'(n) * 32'h8, stackPtr);
    pulse(instrDone);
    chk("busy", 1'b0, busy);
  endtask

  task automatic ret(input logic [7:0] n);
    pulse(retiReq);
    waitHi(retValid);
    chk("retPc", curPc, retPc);
    chk("retSr", curSr, retSr);
    chk("maskLevel", curSr[14:12], maskLevel);
    chk("nestDepth", n, nestDepth);
    chk("stackPtr", 32'(spValue) - 32'(n) * 32'h8, stackPtr);
  endtask

  task automatic none();
    pulse(instrDone);
    waitHi(vecValid);
    chk("vecValid", 1'b0, vecValid);
  endtask

  task automatic t_reset();
    chk("maskLevel", 3'h7, maskLevel);
    chk("nestDepth", 8'h00, nestDepth);
    raise(srcReq, 64'h0C00);
    none();
    raise(swClr, 64'h0800);
    ei(3'h6);
    acc(16'h0028, 8'h0A, 3'h7, 8'h01);
    ret(8'h00);
    none();
  endtask

  // Mid-run reset after the mask has been lowered
  task automatic t_rerst();
    @(negedge clk_sys);
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    chk("maskLevel", 3'h7, maskLevel);
    chk("nestDepth", 8'h00, nestDepth);
    raise(srcReq, 64'h0400);
    none();
  endtask

  task automatic t_tie();
    // Slow memory here to stretch every beat until the final accept
    slow = 1'b1;
    raise(srcReq, 64'h0050_0000);
    acc(16'h0050, 8'h14, 3'h5, 8'h01);
    raise(srcReq, 64'h0100);
    acc(16'h0020, 8'h00, 3'h7, 8'h02);
    pulse(illegalInst);
    acc(16'h0008, 8'h00, 3'h7, 8'h03);
    ret(8'h02);
    ret(8'h01);
    ret(8'h00);
    slow = 1'b0;
    acc(16'h0058, 8'h16, 3'h5, 8'h01);
    ret(8'h00);
  endtask

  task automatic t_levels();
    ei(3'h1);
    raise(srcReq, 64'h0000_8003_4000_0000);
    acc(16'h0084, 8'h21, 3'h3, 8'h01);
    ret(8'h00);
    ei(3'h1);
    acc(16'h0080, 8'h20, 3'h2, 8'h01);
    ret(8'h00);
    ei(3'h1);
    none();
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    {rst_n, illegalInst, instrDone, eiStrobe, retiReq, spLoad, slow} = '0;
    {eiLevel, srcReq, swClr, srcLevel} = '0;
    srcLevel[3*10+:3] = 3'h6;
    srcLevel[3*11+:3] = 3'h6;
    srcLevel[3*20+:3] = 3'h4;
    srcLevel[3*22+:3] = 3'h4;
    srcLevel[3*32+:3] = 3'h1;
    srcLevel[3*33+:3] = 3'h2;
    srcLevel[3*47+:3] = 3'h7;
    curPc = 24'h012345;
    curSr = 16'h4000;
    spValue = 24'h001000;
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    pulse(spLoad);
    t_reset();
    t_tie();
    t_levels();
    t_rerst();
    give_verdict();
  end
endmodule

bind interrupt_accept_vector iav_properties u_props (.*);
